// file: gpx_regs.v
// Register file and pin logic of the 8-pin GPIO expander.
// Function
// - Data writes reach a pin only while that pin is an output.
// - Data reads return the real level on every pin.
// - Direction bit clear makes an output, set makes an input.
// - Direction holds eight bits and resets to all ones.
// - Upper sense register covers pins 7..4, resets to zero.
// - Lower sense register covers pins 3..0, resets to zero.
// - Mask bit clear lets that pin raise an event; resets all ones.
// - Pull-down bit set enables that pin's pull-down; resets zero.
`timescale 1ns/1ps
module gpx_regs
(
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] pin_in,
  output reg  [7:0] pin_out,
  output reg  [7:0] pin_oe,
  output reg  [7:0] pull_high_en,
  output reg  [7:0] pull_low_en,
  output reg        event_irq_n,
  output reg        boost_on
);
`include "gpx_consts.vh"

  // ----------------------------------------------------------------
  // Register storage and internal nets
  // ----------------------------------------------------------------
  // Truth tables 1, 3 and 4 hold no bits; their addresses read as zero.
  reg  [7:0] pin_data;
  reg  [7:0] pin_direction;
  reg  [7:0] event_mask;
  reg  [7:0] edge_sense_upper;
  reg  [7:0] edge_sense_lower;
  reg  [7:0] event_origin;
  reg  [7:0] edge_event_flags;
  reg  [7:0] logic_fn_mode;
  reg  [7:0] logic_table_0;
  reg  [7:0] logic_table_2;
  reg  [7:0] extra_settings;
  wire [7:0] pin_event;
  wire [15:0] sense_all;
  reg  [7:0] next_rdata;
  reg  [7:0] next_out;
  reg  [7:0] clr_origin;
  reg  [7:0] clr_flags;

  // Sense pairs for pins 7..4 sit above those for pins 3..0.
  assign sense_all = {edge_sense_upper, edge_sense_lower};

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // One edge detector per pin, two sense bits each.
  // A pin edge shows up as a one-cycle pulse from the clock edge that first samples it.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_edge
      gpx_pin_edge u_edge
      (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .level       (pin_in[g]),
        .sense       (sense_all[2*g+1:2*g]),
        .event_pulse (pin_event[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writes: configuration registers and write-one-to-clear flags.
  always @*
  begin
    clr_origin = 8'h00;
    clr_flags  = 8'h00;
    if (reg_wr && reg_addr == `GPX_ADDR_EVENT_ORIGIN)
      clr_origin = reg_wdata;
    if (reg_wr && reg_addr == `GPX_ADDR_EVENT_FLAGS)
      clr_flags = reg_wdata;
  end

  // Store host writes and fold pin events into the two status registers.
  // Unused and unmapped addresses fall through the chain and change nothing.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_data         <= `GPX_RST_PIN_DATA;
      pin_direction    <= `GPX_RST_PIN_DIRECTION;
      pull_high_en     <= `GPX_RST_PULL;
      pull_low_en      <= `GPX_RST_PULL;
      event_mask       <= `GPX_RST_EVENT_MASK;
      edge_sense_upper <= `GPX_RST_SENSE;
      edge_sense_lower <= `GPX_RST_SENSE;
      event_origin     <= `GPX_RST_ZERO;
      edge_event_flags <= `GPX_RST_ZERO;
      logic_fn_mode    <= `GPX_RST_ZERO;
      logic_table_0    <= `GPX_RST_ZERO;
      logic_table_2    <= `GPX_RST_ZERO;
      extra_settings   <= `GPX_RST_ZERO;
    end
    else
    begin
      // Event set wins over a clear in the same cycle.
      edge_event_flags <= (edge_event_flags & ~clr_flags) | pin_event;
      event_origin     <= (event_origin & ~clr_origin) | (pin_event & ~event_mask);
      if (reg_wr)
      begin
        if (reg_addr == `GPX_ADDR_PIN_DATA)
          pin_data <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_PIN_DIRECTION)
          pin_direction <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_PULL_HIGH)
          pull_high_en <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_PULL_LOW)
          pull_low_en <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_EVENT_MASK)
          event_mask <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_SENSE_UPPER)
          edge_sense_upper <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_SENSE_LOWER)
          edge_sense_lower <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_LOGIC_MODE)
          logic_fn_mode <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_LOGIC_TABLE_0)
          logic_table_0 <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_LOGIC_TABLE_2)
          logic_table_2 <= reg_wdata;
        else if (reg_addr == `GPX_ADDR_EXTRA)
          extra_settings <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux; unmapped and unused addresses read a fixed value.
  always @*
  begin
    next_rdata = `GPX_UNUSED_READ;
    if (reg_addr == `GPX_ADDR_PIN_DATA)
      next_rdata = pin_in;
    else if (reg_addr == `GPX_ADDR_PIN_DIRECTION)
      next_rdata = pin_direction;
    else if (reg_addr == `GPX_ADDR_PULL_HIGH)
      next_rdata = pull_high_en;
    else if (reg_addr == `GPX_ADDR_PULL_LOW)
      next_rdata = pull_low_en;
    else if (reg_addr == `GPX_ADDR_EVENT_MASK)
      next_rdata = event_mask;
    else if (reg_addr == `GPX_ADDR_SENSE_UPPER)
      next_rdata = edge_sense_upper;
    else if (reg_addr == `GPX_ADDR_SENSE_LOWER)
      next_rdata = edge_sense_lower;
    else if (reg_addr == `GPX_ADDR_EVENT_ORIGIN)
      next_rdata = event_origin;
    else if (reg_addr == `GPX_ADDR_EVENT_FLAGS)
      next_rdata = edge_event_flags;
    else if (reg_addr == `GPX_ADDR_LOGIC_MODE)
      next_rdata = logic_fn_mode;
    else if (reg_addr == `GPX_ADDR_LOGIC_TABLE_0)
      next_rdata = logic_table_0;
    else if (reg_addr == `GPX_ADDR_LOGIC_TABLE_2)
      next_rdata = logic_table_2;
    else if (reg_addr == `GPX_ADDR_EXTRA)
      next_rdata = extra_settings;
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Output value per pin, with the truth-table modes overriding pins 2 and 3.
  // Mode 11 is unused and leaves every pin on the data register.
  always @*
  begin
    next_out = pin_data;
    if (logic_fn_mode[1:0] == 2'b01)
      next_out[2] = logic_table_0[pin_in[1:0]];
    else if (logic_fn_mode[1:0] == 2'b10)
      next_out[3] = logic_table_2[pin_in[2:0]];
  end

  // Registered outputs toward the pins and the host.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      reg_rdata   <= `GPX_RST_ZERO;
      pin_out     <= `GPX_RST_PIN_DATA;
      pin_oe      <= 8'h00;
      event_irq_n <= 1'b1;
      boost_on    <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= next_rdata;
      // A set direction bit clears the drive enable and releases the pin.
      // The event pin stays low while any unmasked event is still pending.
      // drive outputs only
      pin_out     <= next_out;
      pin_oe      <= ~pin_direction;
      event_irq_n <= ~(|event_origin);
      boost_on    <= extra_settings[1];
    end
  end
endmodule

// file: gpx_consts.vh
// Register offsets, reset values and field positions of the 8-pin GPIO expander.
`ifndef GPX_CONSTS_VH
`define GPX_CONSTS_VH
`define GPX_ADDR_PIN_DATA        8'h00
`define GPX_ADDR_PIN_DIRECTION   8'h01
`define GPX_ADDR_PULL_HIGH       8'h02
`define GPX_ADDR_PULL_LOW        8'h03
`define GPX_ADDR_UNUSED_SLOT     8'h04
`define GPX_ADDR_EVENT_MASK      8'h05
`define GPX_ADDR_SENSE_UPPER     8'h06
`define GPX_ADDR_SENSE_LOWER     8'h07
`define GPX_ADDR_EVENT_ORIGIN    8'h08
`define GPX_ADDR_EVENT_FLAGS     8'h09
`define GPX_ADDR_LOGIC_MODE      8'h10
`define GPX_ADDR_LOGIC_TABLE_0   8'h11
`define GPX_ADDR_LOGIC_TABLE_1   8'h12
`define GPX_ADDR_LOGIC_TABLE_2   8'h13
`define GPX_ADDR_LOGIC_TABLE_3   8'h14
`define GPX_ADDR_LOGIC_TABLE_4   8'h15
`define GPX_ADDR_EXTRA           8'hab
`define GPX_RST_PIN_DATA         8'hff
`define GPX_RST_PIN_DIRECTION    8'hff
`define GPX_RST_PULL             8'h00
`define GPX_RST_EVENT_MASK       8'hff
`define GPX_RST_SENSE            8'h00
`define GPX_RST_ZERO             8'h00
`define GPX_UNUSED_READ          8'h00
`define GPX_SENSE_RISE           1
`define GPX_SENSE_FALL           0
`endif

// file: gpx_pin_edge.v
// Edge detector for one pin with two sense bits selecting rising, falling or both.
`timescale 1ns/1ps
module gpx_pin_edge
(
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       level,
  input  wire [1:0] sense,
  output reg        event_pulse
);
`include "gpx_consts.vh"

  reg prev_level;

  // Compare against the previous level and report a selected edge.
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // Track the pin during reset so the first cycle after it sees no false edge.
      prev_level  <= level;
      event_pulse <= 1'b0;
    end
    else
    begin
      prev_level  <= level;
      event_pulse <= (sense[`GPX_SENSE_RISE] & level & ~prev_level) |
                     (sense[`GPX_SENSE_FALL] & ~level & prev_level);
    end
  end
endmodule

// file: gpx_pin_side.sv
// Pin-side model of the logic wired to the eight expander pins.
`timescale 1ns/1ps
module gpx_pin_side
(
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // A pin follows the device where it drives and the outside driver elsewhere.
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// file: gpx_regs_properties.sv
// Checker of the register and pin ports of the expander.
`timescale 1ns/1ps
module gpx_regs_chk
(
  input       mclk,
  input       rst_n,
  input [7:0] reg_addr,
  input [7:0] reg_wdata,
  input       reg_wr,
  input       reg_rd,
  input [7:0] reg_rdata,
  input [7:0] pin_in,
  input [7:0] pin_out,
  input [7:0] pin_oe,
  input [7:0] pull_high_en,
  input [7:0] pull_low_en,
  input       event_irq_n,
  input       boost_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Pull-down write reaches its output on the next edge.
  property p_pull;
    reg_wr && reg_addr == 8'h03 |=> pull_low_en == $past(reg_wdata);
  endproperty
  a_read_pin_level:
    assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(pin_in))
    else $error("pin read wrong");
  a_dir_to_oe:
    assert property (reg_wr && reg_addr == 8'h01 |=> ##1 pin_oe == ~$past(reg_wdata, 2))
    else $error("drive enable wrong");
  a_dir_readback:
    assert property (reg_rd && reg_addr == 8'h01 |=> reg_rdata == ~pin_oe)
    else $error("direction read wrong");
  a_reset_outputs:
    assert property ($rose(rst_n) |-> pin_oe == 8'h00 && pull_low_en == 8'h00)
    else $error("reset outputs wrong");
  a_pull_low_write:
    assert property (p_pull)
    else $error("pull-down not applied");
  a_irq_quiet:
    assert property ($rose(rst_n) |-> event_irq_n [*3])
    else $error("event after reset");
  a_unused_zero:
    assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00)
    else $error("unused slot read wrong");
  a_rdata_holds:
    assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_data_drive:
    assert property (reg_wr && reg_addr == 8'h00 |=>
      ##1 ((pin_out ^ $past(reg_wdata, 2)) & pin_oe & 8'hf3) == 8'h00)
    else $error("driven pin data wrong");
  a_irq_from_edge:
    assert property ($fell(event_irq_n) |-> $past(pin_in, 3) != $past(pin_in, 4))
    else $error("event without pin edge");
  c_sense: cover property (reg_wr && reg_addr == 8'h06);
  c_logic_mode: cover property (reg_wr && reg_addr == 8'h10);
  c_unused: cover property (reg_rd && reg_addr == 8'h04);
  c_event: cover property ($fell(event_irq_n));
endmodule
bind gpx_regs gpx_regs_chk i_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_high_en(pull_high_en),
  .pull_low_en(pull_low_en), .event_irq_n(event_irq_n), .boost_on(boost_on));

// file: testbench.sv
// Testbench of the expander register file and pins.
`timescale 1ns/1ps
module testbench;
  logic       mclk = 0;
  logic       rst_n = 0;
  logic [7:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  logic       reg_wr = 0;
  logic       reg_rd = 0;
  logic [7:0] ext = 8'h3c;
  wire  [7:0] reg_rdata, pin_in, pin_out, pin_oe, pull_high_en, pull_low_en;
  wire        event_irq_n, boost_on;
  int         mismatches = 0;
  int         checks_done = 0;
  logic [7:0] ra [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
  logic [7:0] rv [9] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  // Clock of 4 ns period.
  always #2 mclk = ~mclk;
  gpx_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_high_en(pull_high_en),
    .pull_low_en(pull_low_en), .event_irq_n(event_irq_n), .boost_on(boost_on));
  gpx_pin_side i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  // Counts a comparison and reports a mismatch.
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle write strobe.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  // One-cycle read strobe, data checked once it has landed.
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    @(posedge mclk);
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset, reset values, write paths, pins, events, truth tables, second reset.
  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h06, 8'ha5);
    wr(8'h07, 8'h5a);
    wr(8'h03, 8'h3c);
    wr(8'h04, 8'h77);
    wr(8'h02, 8'hc3);
    rd(8'h06, 8'ha5);
    rd(8'h07, 8'h5a);
    rd(8'h03, 8'h3c);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'hc3);
    chk("pull_low_en", pull_low_en, 8'h3c);
    chk("pull_high_en", pull_high_en, 8'hc3);
    wr(8'h00, 8'ha5);
    rd(8'h00, 8'h3c);
    wr(8'h01, 8'h0f);
    wr(8'h00, 8'ha5);
    rd(8'h00, 8'hac);
    chk("pin_oe", pin_oe, 8'hf0);
    chk("pin_out", pin_out, 8'ha5);
    wr(8'h05, 8'hfe);
    wr(8'h07, 8'h03);
    ext <= 8'h3d;
    repeat (4) @(posedge mclk);
    #1 chk("event_irq_n", {7'h00, event_irq_n}, 8'h00);
    rd(8'h08, 8'h01);
    // Pins 7 and 4 flagged when they turned into outputs, pin 0 by its edge.
    rd(8'h09, 8'h91);
    wr(8'h09, 8'h90);
    rd(8'h09, 8'h01);
    wr(8'h08, 8'h01);
    rd(8'h08, 8'h00);
    chk("event_irq_n", {7'h00, event_irq_n}, 8'h01);
    // Two-input table drives pin 2 from pins 1..0.
    wr(8'h01, 8'h0b);
    wr(8'h11, 8'h0d);
    wr(8'h10, 8'h01);
    rd(8'h00, 8'ha9);
    // Three-input table drives pin 3 from pins 2..0.
    wr(8'h13, 8'h20);
    wr(8'h10, 8'h02);
    wr(8'h01, 8'h03);
    rd(8'h00, 8'had);
    chk("pin_out", pin_out, 8'had);
    wr(8'hab, 8'h02);
    @(posedge mclk);
    #1 chk("boost_on", {7'h00, boost_on}, 8'h01);
    // Second reset in mid-run must bring direction, mask, pull-down and both sense registers back.
    @(posedge mclk);
    rst_n <= 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    rd(8'h01, 8'hff);
    rd(8'h05, 8'hff);
    rd(8'h03, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    chk("pin_oe", pin_oe, 8'h00);
    chk("pull_low_en", pull_low_en, 8'h00);
    chk("event_irq_n", {7'h00, event_irq_n}, 8'h01);
    chk("boost_on", {7'h00, boost_on}, 8'h00);
    tally_and_finish;
  end
  // Watchdog against a hang.
  initial
  begin
    #4000;
    mismatches++;
    tally_and_finish;
  end
endmodule
